// *** hw/timer_pkg.sv ***
// package of constants and types shared by the reload and one-shot timers
`default_nettype none
package timer_pkg;
  // ***********************
  // mode register fields
  // ***********************
  localparam int RELOAD_SEL_DIV64 = 0; // internal clock: osc or osc/64
  localparam int RELOAD_SEL_EXT = 1; // source: internal or count pin
  localparam int RELOAD_SEL_MFP = 2; // pin: generator or timer tone
  localparam int RUN_BIT = 3; // run bit in both mode registers
  localparam int ONESHOT_SEL_DIV1024 = 0; // osc/4 or osc/1024
  // ***********************
  // reset values and counts
  // ***********************
  localparam logic [3:0] MODE_RESET = 4'h0; // reload undivided osc, one-shot osc/4, stopped
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] UNDERFLOW_VALUE = 8'hFF; // count wraps to this
  localparam int DIV64_CYCLES = 64;
  localparam int DIV4_CYCLES = 4;
  localparam int DIV1024_CYCLES = 1024;
  localparam int PRESCALE_WIDTH = 10; // wide enough for 1024
  // ***********************
  // register-write commands
  // ***********************
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_LOW_NIBBLE = 3'b001,
    CMD_HIGH_NIBBLE = 3'b010,
    CMD_IMMEDIATE = 3'b011,
    CMD_MODE = 3'b100
  } timer_cmd_t;
endpackage : timer_pkg
`default_nettype wire

// *** hw/tick_divider.sv ***
// divider making a one-cycle enable every DIVIDE clocks
`default_nettype none
module tick_divider #(
  parameter int DIVIDE = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic tick
);
  // ***********************
  // state
  // ***********************
  typedef struct packed {
    logic [timer_pkg::PRESCALE_WIDTH-1:0] count; // cycles since last tick
    logic tick; // registered enable pulse
  } div_state_t;
  div_state_t state;
  div_state_t next_state;
  localparam logic [timer_pkg::PRESCALE_WIDTH-1:0] LAST =
    timer_pkg::PRESCALE_WIDTH'(DIVIDE - 1);
  // free-running count; tick on the wrap
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.count == LAST) begin
      next_state.count = '0;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 1'b1;
    end
  end
  // register the copy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign tick = state.tick;
endmodule : tick_divider
`default_nettype wire

// *** hw/oneshot_timer.sv ***
// one-shot 8-bit down counter with its write-only mode register
`default_nettype none
module oneshot_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire timer_pkg::timer_cmd_t cmd,
  input wire logic [7:0] data,
  input wire logic tickDiv4,
  input wire logic tickDiv1024,
  output logic [7:0] count,
  output logic running,
  output logic underflow
);
  // ***********************
  // state
  // ***********************
  typedef struct packed {
    logic [3:0] mode; // oneshot_timer_mode
    logic [7:0] count; // counter value
    logic underflow; // one-cycle event pulse
  } os_state_t;
  os_state_t state;
  os_state_t next_state;
  logic tick; // selected input clock enable
  // input clock choice, reserved bits ignored
  always_comb begin
    tick = state.mode[timer_pkg::ONESHOT_SEL_DIV1024] ? tickDiv1024 : tickDiv4;
  end
  // commands first, then counting
  always_comb begin
    next_state = state;
    next_state.underflow = 1'b0;
    case (cmd)
      timer_pkg::CMD_LOW_NIBBLE: begin
        next_state.count[3:0] = data[3:0];
        next_state.mode[timer_pkg::RUN_BIT] = 1'b0;
      end
      timer_pkg::CMD_HIGH_NIBBLE: begin
        next_state.count[7:4] = data[3:0];
        next_state.mode[timer_pkg::RUN_BIT] = 1'b0;
      end
      timer_pkg::CMD_IMMEDIATE: begin
        next_state.count = data;
        next_state.mode[timer_pkg::RUN_BIT] = 1'b1;
      end
      timer_pkg::CMD_MODE: begin
        next_state.mode = data[3:0];
      end
      default: begin
        // count only while running
        if (state.mode[timer_pkg::RUN_BIT] && tick) begin
          next_state.count = state.count - 1'b1;
          if (state.count == 8'h00) begin
            // reaching the wrap value stops the timer
            next_state.mode[timer_pkg::RUN_BIT] = 1'b0;
            next_state.underflow = 1'b1;
          end
        end
      end
    endcase
  end
  // register the copy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{mode: timer_pkg::MODE_RESET, count: timer_pkg::COUNT_RESET, underflow: 1'b0};
    end else begin
      state <= next_state;
    end
  end
  assign count = state.count;
  assign running = state.mode[timer_pkg::RUN_BIT];
  assign underflow = state.underflow;
endmodule : oneshot_timer
`default_nettype wire

// *** hw/reload_and_oneshot_timers.sv ***
// top: auto-reload timer, one-shot timer, event flags and tone output
//
// Contract
// - reload timer is 8-bit down counter
// - mode bit0 picks osc or osc/64
// - mode bit1 picks internal or count pin
// - count pin falling edge decrements by one
// - reset selects undivided oscillator clock
// - nibble write loads buffer, clears run
// - run set loads counter, clears flag 7
// - immediate load clears flag, loads, runs
// - wrap to FFH sets flag, reloads, continues
// - underflow gated to interrupt and hold release
// - mode bit2 picks generator or timer tone
// - period is preset plus one input ticks
// - tone is input over preset+1 over 2
// - mode bit3 gates reload counting
// - one-shot bit0 picks osc/4 or osc/1024
// - one-shot bit3 gates counting
// - one-shot nibble load stops, clears run
// - one-shot run set clears flag 1
// - one-shot stops at FFH, sets flag 1
`default_nettype none
module reload_and_oneshot_timers (
  input wire logic clock,
  input wire logic rst_n,
  input wire timer_pkg::timer_cmd_t reloadCmd, // write to reload timer or its mode
  input wire logic [7:0] reloadData, // nibble in [3:0] or full immediate
  input wire timer_pkg::timer_cmd_t oneshotCmd, // write to one-shot timer or its mode
  input wire logic [7:0] oneshotData,
  input wire logic clearFlags, // software clear of both event flags
  input wire logic externalCountPin, // asynchronous count pin
  input wire logic generatorWave, // waveform from the output generator
  input wire logic [1:0] interruptEnable, // [1] reload, [0] one-shot
  input wire logic [1:0] holdReleaseEnable, // [1] reload, [0] one-shot
  output logic [7:0] reloadCount,
  output logic [7:0] oneshotCount,
  output logic reloadFlag, // event flag 7
  output logic oneshotFlag, // event flag 1
  output logic interruptRequest, // one-cycle pulse
  output logic holdRelease, // one-cycle pulse
  output logic multiFunctionOutput
);
  // ***********************
  // dividers
  // ***********************
  logic tick64;
  logic tick4;
  logic tick1024;
  tick_divider #(.DIVIDE(timer_pkg::DIV64_CYCLES)) div64 (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick64)
  );
  tick_divider #(.DIVIDE(timer_pkg::DIV4_CYCLES)) div4 (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick4)
  );
  tick_divider #(.DIVIDE(timer_pkg::DIV1024_CYCLES)) div1024 (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick1024)
  );
  // ***********************
  // one-shot timer
  // ***********************
  logic [7:0] osCount;
  logic osRunning;
  logic osUnderflow;
  oneshot_timer oneshot (
    .clock(clock),
    .rst_n(rst_n),
    .cmd(oneshotCmd),
    .data(oneshotData),
    .tickDiv4(tick4),
    .tickDiv1024(tick1024),
    .count(osCount),
    .running(osRunning),
    .underflow(osUnderflow)
  );
  // ***********************
  // state
  // ***********************
  typedef struct packed {
    logic [1:0] pinSync; // two-stage synchroniser
    logic pinLast; // previous synchronised level
    logic [3:0] mode; // reload_timer_mode
    logic [7:0] buffer; // auto-reload buffer
    logic [7:0] count; // down counter
    logic toneLevel; // square-wave level
    logic reloadFlag;
    logic oneshotFlag;
    logic osRunLast; // edge detect of one-shot run
    logic interruptRequest;
    logic holdRelease;
    logic [7:0] osCount;
    logic multi_function_output;
  } top_state_t;
  top_state_t state;
  top_state_t next_state;
  logic pinFall; // falling edge of synchronised pin
  logic reloadTick; // selected input clock enable
  logic reloadUnder; // underflow this cycle
  logic reloadRunSet; // rising run bit from a mode write
  logic osRunSet;
  // ***********************
  // clock selection
  // ***********************
  // only the second stage feeds the edge detector
  always_comb begin
    pinFall = state.pinLast && !state.pinSync[1];
    if (state.mode[timer_pkg::RELOAD_SEL_EXT]) begin
      reloadTick = pinFall;
    end else if (state.mode[timer_pkg::RELOAD_SEL_DIV64]) begin
      reloadTick = tick64;
    end else begin
      reloadTick = 1'b1;
    end
    reloadRunSet = (reloadCmd == timer_pkg::CMD_MODE) && reloadData[timer_pkg::RUN_BIT]
      && !state.mode[timer_pkg::RUN_BIT];
    osRunSet = osRunning && !state.osRunLast;
    reloadUnder = (reloadCmd == timer_pkg::CMD_NONE) && state.mode[timer_pkg::RUN_BIT]
      && reloadTick && (state.count == 8'h00);
  end
  // ***********************
  // next state
  // ***********************
  // commands win over counting; event set wins over any clear
  always_comb begin
    next_state = state;
    next_state.pinSync = {state.pinSync[0], externalCountPin};
    next_state.pinLast = state.pinSync[1];
    next_state.osRunLast = osRunning;
    next_state.osCount = osCount;
    case (reloadCmd)
      timer_pkg::CMD_LOW_NIBBLE: begin
        next_state.buffer[3:0] = reloadData[3:0];
        next_state.mode[timer_pkg::RUN_BIT] = 1'b0;
      end
      timer_pkg::CMD_HIGH_NIBBLE: begin
        next_state.buffer[7:4] = reloadData[3:0];
        next_state.mode[timer_pkg::RUN_BIT] = 1'b0;
      end
      timer_pkg::CMD_IMMEDIATE: begin
        next_state.buffer = reloadData;
        next_state.count = reloadData;
        next_state.mode[timer_pkg::RUN_BIT] = 1'b1;
        next_state.reloadFlag = 1'b0;
      end
      timer_pkg::CMD_MODE: begin
        next_state.mode = reloadData[3:0];
        if (reloadRunSet) begin
          next_state.count = state.buffer;
          next_state.reloadFlag = 1'b0;
        end
      end
      default: begin
        if (state.mode[timer_pkg::RUN_BIT] && reloadTick) begin
          // preset+1 ticks per period
          next_state.count = state.count - 1'b1;
          if (reloadUnder) begin
            next_state.count = state.buffer;
            next_state.toneLevel = !state.toneLevel;
          end
        end
      end
    endcase
    if (clearFlags) begin
      next_state.reloadFlag = 1'b0;
      next_state.oneshotFlag = 1'b0;
    end
    if (osRunSet) begin
      next_state.oneshotFlag = 1'b0;
    end
    if (reloadUnder) begin
      next_state.reloadFlag = 1'b1;
    end
    if (osUnderflow) begin
      next_state.oneshotFlag = 1'b1;
    end
    next_state.interruptRequest = (reloadUnder && interruptEnable[1])
      || (osUnderflow && interruptEnable[0]);
    next_state.holdRelease = (reloadUnder && holdReleaseEnable[1])
      || (osUnderflow && holdReleaseEnable[0]);
    next_state.multi_function_output = state.mode[timer_pkg::RELOAD_SEL_MFP] ? state.toneLevel
      : generatorWave;
  end
  // ***********************
  // registers
  // ***********************
  // reset leaves undivided oscillator selected, timer stopped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.pinSync <= 2'h3; // idle high pin, no false edge
      state.pinLast <= 1'b1;
      state.mode <= timer_pkg::MODE_RESET;
      state.buffer <= timer_pkg::COUNT_RESET;
      state.count <= timer_pkg::COUNT_RESET;
    end else begin
      state <= next_state;
    end
  end
  // outputs straight from the state register
  assign reloadCount = state.count;
  assign oneshotCount = state.osCount;
  assign reloadFlag = state.reloadFlag;
  assign oneshotFlag = state.oneshotFlag;
  assign interruptRequest = state.interruptRequest;
  assign holdRelease = state.holdRelease;
  assign multiFunctionOutput = state.multi_function_output;
endmodule : reload_and_oneshot_timers
`default_nettype wire

// *** tb/pulse_source.sv ***
// far-side model: falling-edge pulse trains on the count pin
`default_nettype none
module pulse_source #(
  parameter int PULSES = 3 // falling edges per request
) (
  input wire logic clock,
  input wire logic start, // request, seen on a rising edge
  output logic countPin, // idle high between trains
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    countPin = 1'b1;
    busy = 1'b0;
  end
  // ***********************
  // pulse train
  // ***********************
  // four cycles low and four high, slow enough for a two-stage sync
  always @(posedge clock) begin
    if (start) begin
      busy = 1'b1;
      repeat (PULSES) begin
        #1 countPin = 1'b0;
        repeat (4) @(posedge clock);
        #1 countPin = 1'b1;
        repeat (4) @(posedge clock);
      end
      busy = 1'b0; // dropped on the edge so the bench sees it settled
    end
  end
endmodule : pulse_source
`default_nettype wire

// *** tb/timers_sva.sv ***
// assertions on the timer block's ports
`default_nettype none
module timers_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire timer_pkg::timer_cmd_t reloadCmd,
  input wire logic [7:0] reloadData,
  input wire logic generatorWave,
  input wire logic [1:0] interruptEnable,
  input wire logic [1:0] holdReleaseEnable,
  input wire logic [7:0] reloadCount,
  input wire logic [7:0] oneshotCount,
  input wire logic reloadFlag,
  input wire logic oneshotFlag,
  input wire logic interruptRequest,
  input wire logic holdRelease,
  input wire logic multiFunctionOutput
);
  logic [3:0] mode; // shadow mode, bit3 is run
  logic [7:0] buffer; // shadow reload buffer
  // ***********************
  // shadow of write-only state
  // ***********************
  // mode cannot be read back, so it is rebuilt from the writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode <= 4'h0;
      buffer <= 8'h00;
    end else begin
      case (reloadCmd)
        timer_pkg::CMD_LOW_NIBBLE: begin
          buffer[3:0] <= reloadData[3:0];
          mode[3] <= 1'b0;
        end
        timer_pkg::CMD_HIGH_NIBBLE: begin
          buffer[7:4] <= reloadData[3:0];
          mode[3] <= 1'b0;
        end
        timer_pkg::CMD_IMMEDIATE: begin
          buffer <= reloadData;
          mode[3] <= 1'b1;
        end
        timer_pkg::CMD_MODE: mode <= reloadData[3:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_imm;
    reloadCmd == timer_pkg::CMD_IMMEDIATE |=> reloadCount == $past(reloadData) && !reloadFlag;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate load wrong");
  property p_stop;
    !mode[3] && reloadCmd == timer_pkg::CMD_NONE |=> $stable(reloadCount);
  endproperty
  a_stop: assert property (p_stop) else $error("counted while stopped");
  property p_run;
    reloadCmd == timer_pkg::CMD_MODE && reloadData[3] && !mode[3]
      |=> reloadCount == buffer && !reloadFlag;
  endproperty
  a_run: assert property (p_run) else $error("run start wrong");
  property p_wrap;
    $rose(reloadFlag) |-> $past(reloadCount) == 8'h00 && reloadCount == buffer;
  endproperty
  a_wrap: assert property (p_wrap) else $error("underflow wrong");
  property p_irq;
    $rose(reloadFlag) && interruptEnable[1] |-> interruptRequest;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt pulse");
  property p_hold;
    $rose(reloadFlag) && holdReleaseEnable[1] |-> holdRelease;
  endproperty
  a_hold: assert property (p_hold) else $error("no hold release pulse");
  property p_gen;
    !mode[2] && !$past(mode[2]) |-> multiFunctionOutput == $past(generatorWave);
  endproperty
  a_gen: assert property (p_gen) else $error("generator not routed");
  property p_tone;
    mode[2] && $past(mode[2]) && $past(mode[2], 2) && $changed(multiFunctionOutput)
      |-> $past(reloadCount, 2) == 8'h00;
  endproperty
  a_tone: assert property (p_tone) else $error("tone moved off underflow");
  property p_shot;
    $rose(oneshotFlag) |-> ##2 (oneshotCount == 8'hFF) [*3];
  endproperty
  a_shot: assert property (p_shot) else $error("one-shot did not stop");
endmodule : timers_sva
bind reload_and_oneshot_timers timers_sva u_sva (
  .clock(clock), .rst_n(rst_n), .reloadCmd(reloadCmd), .reloadData(reloadData),
  .generatorWave(generatorWave), .interruptEnable(interruptEnable),
  .holdReleaseEnable(holdReleaseEnable), .reloadCount(reloadCount),
  .oneshotCount(oneshotCount), .reloadFlag(reloadFlag), .oneshotFlag(oneshotFlag),
  .interruptRequest(interruptRequest), .holdRelease(holdRelease),
  .multiFunctionOutput(multiFunctionOutput)
);
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the reload and one-shot timers
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0; // 125 MHz
  logic rst_n = 1'b0;
  timer_pkg::timer_cmd_t reloadCmd = timer_pkg::CMD_NONE;
  timer_pkg::timer_cmd_t oneshotCmd = timer_pkg::CMD_NONE;
  logic [7:0] reloadData = 8'h00;
  logic [7:0] oneshotData = 8'h00;
  logic clearFlags = 1'b0;
  logic generatorWave = 1'b0;
  logic [1:0] enables = 2'h3; // interrupt and hold enables, both timers
  logic start = 1'b0; // pulse train request
  wire externalCountPin;
  wire busy;
  wire [7:0] reloadCount;
  wire [7:0] oneshotCount;
  wire reloadFlag;
  wire oneshotFlag;
  wire interruptRequest;
  wire holdRelease;
  wire multiFunctionOutput;
  int errors = 0;
  int checked = 0;
  int n; // cycles spent in the last wait
  logic [7:0] c;
  always #4 clock = ~clock;
  reload_and_oneshot_timers u_dut (
    .clock(clock), .rst_n(rst_n), .reloadCmd(reloadCmd), .reloadData(reloadData),
    .oneshotCmd(oneshotCmd), .oneshotData(oneshotData), .clearFlags(clearFlags),
    .externalCountPin(externalCountPin), .generatorWave(generatorWave),
    .interruptEnable(enables), .holdReleaseEnable(enables), .reloadCount(reloadCount),
    .oneshotCount(oneshotCount), .reloadFlag(reloadFlag), .oneshotFlag(oneshotFlag),
    .interruptRequest(interruptRequest), .holdRelease(holdRelease),
    .multiFunctionOutput(multiFunctionOutput)
  );
  pulse_source u_src (.clock(clock), .start(start), .countPin(externalCountPin), .busy(busy));
  // ***********************
  // helpers
  // ***********************
  task tick; // inputs always move 1 ns after the edge
    @(posedge clock);
    #1;
  endtask : tick
  task results;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // one command cycle on either timer, then back to idle
  task cmd(input bit one, input timer_pkg::timer_cmd_t k, input logic [7:0] d);
    if (one) begin
      oneshotCmd = k;
      oneshotData = d;
    end else begin
      reloadCmd = k;
      reloadData = d;
    end
    tick;
    reloadCmd = timer_pkg::CMD_NONE;
    oneshotCmd = timer_pkg::CMD_NONE;
  endtask : cmd
  function automatic logic [7:0] val(input int w);
    case (w)
      0: return {7'h00, multiFunctionOutput};
      1: return {7'h00, oneshotFlag};
      2: return reloadCount;
      default: return {7'h00, busy};
    endcase
  endfunction : val
  // bounded wait for a watched value to move
  task waitChg(input int w);
    logic [7:0] v;
    v = val(w);
    n = 0;
    while (val(w) === v && n < 2000) begin
      tick;
      n++;
    end
    if (n >= 2000) begin
      errors++;
      results;
    end
  endtask : waitChg
  // ***********************
  // scenarios
  // ***********************
  initial begin
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk("flags", 8'h00, {reloadCount[7:2], oneshotFlag, reloadFlag});
    generatorWave = 1'b1;
    tick;
    tick;
    chk("mfp", 8'h01, val(0));
    generatorWave = 1'b0;
    cmd(1'b0, timer_pkg::CMD_IMMEDIATE, 8'h02);
    for (int i = 0; i < 4; i++) begin
      chk("count", (i == 3) ? 8'h02 : 8'h02 - 8'(i), reloadCount);
      if (i < 3) tick;
    end
    // pulses stand in the same cycle that the flag rises
    chk("event", 8'h07, {5'h00, interruptRequest, holdRelease, reloadFlag});
    tick;
    cmd(1'b0, timer_pkg::CMD_MODE, 8'h0C);
    repeat (3) waitChg(0);
    chk("tone", 8'h03, n[7:0]);
    cmd(1'b0, timer_pkg::CMD_LOW_NIBBLE, 8'h05);
    cmd(1'b0, timer_pkg::CMD_HIGH_NIBBLE, 8'h00);
    c = reloadCount;
    repeat (10) tick;
    chk("stop", c, reloadCount);
    cmd(1'b0, timer_pkg::CMD_MODE, 8'h09);
    chk("load", 8'h05, reloadCount);
    chk("flag7", 8'h00, {7'h00, reloadFlag});
    waitChg(2);
    waitChg(2);
    chk("div64", 8'h40, n[7:0]);
    cmd(1'b0, timer_pkg::CMD_MODE, 8'h0A);
    c = reloadCount;
    start = 1'b1;
    tick;
    start = 1'b0;
    waitChg(3);
    repeat (4) tick;
    chk("extern", c - 8'h03, reloadCount);
    cmd(1'b1, timer_pkg::CMD_IMMEDIATE, 8'h01);
    waitChg(1);
    chk("shot", 8'h01, 8'(n >= 5 && n <= 12));
    repeat (3) tick;
    chk("ff", 8'hFF, oneshotCount);
    cmd(1'b1, timer_pkg::CMD_MODE, 8'h08);
    repeat (3) tick;
    chk("clear", 8'h00, val(1));
    waitChg(1);
    chk("rerun", 8'h01, 8'(n >= 1015 && n <= 1030));
    clearFlags = 1'b1;
    tick;
    clearFlags = 1'b0;
    tick;
    chk("cleared", 8'h00, {6'h00, oneshotFlag, reloadFlag});
    // let the stopped count stand a while before reloading it
    repeat (4) tick;
    cmd(1'b1, timer_pkg::CMD_MODE, 8'h08);
    cmd(1'b1, timer_pkg::CMD_LOW_NIBBLE, 8'h03);
    cmd(1'b1, timer_pkg::CMD_HIGH_NIBBLE, 8'h00);
    repeat (12) tick;
    chk("osload", 8'h03, oneshotCount);
    results;
  end
endmodule : tb
`default_nettype wire
